// ===== dv/sound_tone_generator_asserts.sv
// port assertions for the sound tone generator
`timescale 1ns/1ps
`default_nettype none
module sound_tone_generator_asserts (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [17:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tonePlainOut,
   input wire logic toneGatedOut,
   input wire logic amplitudePwmOut,
   input wire logic clockOutFunction
);
   logic wCtl;
   logic anyOut;
   // completed control write, and any speaker pin high
   assign wCtl = psel && penable && pready && pwrite && pstrb[0] && paddr == 18'h3_ff00;
   assign anyOut = tonePlainOut | toneGatedOut | amplitudePwmOut;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   // bus answer timing and read data
   rdy_setup_a: assert property (psel && !penable |=> pready) else $error("late ready");
   rdy_pulse_a: assert property (pready |=> !pready) else $error("long ready");
   rd_upper_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
   err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   // output selection
   gated_sel_a: assert property (toneGatedOut |-> clockOutFunction && !amplitudePwmOut) else $error("gated");
   plain_sel_a: assert property (tonePlainOut || amplitudePwmOut |-> !clockOutFunction) else $error("plain");
   sel_track_a: assert property (wCtl |=> ##1 clockOutFunction == $past(pwdata[3], 2)) else $error("select");
   // stop and reset force pins low, tone rises only after a long low
   stop_low_a: assert property (wCtl && !pwdata[7] |=> ##3 !anyOut) else $error("not stopped");
   reset_low_a: assert property (disable iff (1'b0) srst |=> !anyOut && !clockOutFunction) else $error("reset");
   tone_low_a: assert property ($rose(tonePlainOut) |-> !$past(tonePlainOut, 2) && !$past(tonePlainOut, 8))
      else $error("short low");
   cover property (wCtl && pwdata[7]);
   cover property (toneGatedOut);
   cover property (pslverr);
endmodule // sound_tone_generator_asserts
bind sound_tone_generator sound_tone_generator_asserts i_chk (.clk, .srst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pready, .pslverr, .tonePlainOut, .toneGatedOut, .amplitudePwmOut, .clockOutFunction);
`default_nettype wire

// ===== dv/speaker_model.sv
// speaker model: tone half period and pin high time
`timescale 1ns/1ps
`default_nettype none
module speaker_model (
   input wire logic clk,
   input wire logic clr,
   input wire logic tonePlainOut,
   input wire logic toneGatedOut,
   input wire logic amplitudePwmOut,
   output var int half,
   output var int edges,
   output var int ampHigh,
   output var int gatedHigh
);
   int since = 0;
   logic last = 1'b0;
   logic tone;
   // the speaker hears either tone pin
   assign tone = tonePlainOut | toneGatedOut;
   // time between tone edges, high-cycle counts since clear
   always @(posedge clk)
   begin
      last <= tone;
      since <= (last != tone) ? 1 : since + 1;
      if (last != tone)
         half <= since;
      edges <= clr ? 0 : edges + int'(last != tone);
      ampHigh <= clr ? 0 : ampHigh + int'(amplitudePwmOut);
      gatedHigh <= clr ? 0 : gatedHigh + int'(toneGatedOut);
   end
endmodule // speaker_model
`default_nettype wire

// ===== dv/test_sound_tone_generator.sv
// self-checking bench for the sound tone generator
`timescale 1ns/1ps
`default_nettype none
module test_sound_tone_generator;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0, se;
   logic [3:0] pstrb = 4'hf;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, tonePlainOut, toneGatedOut, amplitudePwmOut, clockOutFunction;
   logic [31:0] codes [5] = '{32'h0, 32'h1, 32'h5, 32'h40, 32'h7f};
   int errors = 0, checks_done = 0, half, edges, ampHigh, gatedHigh;
   localparam logic [17:0] CTL = 18'h3_ff00, AMP = 18'h3_ff04, DIV = 18'h3_ff08, BITW = 18'h3_ff0c;
   sound_tone_generator i_dut (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr, .tonePlainOut, .toneGatedOut, .amplitudePwmOut, .clockOutFunction);
   speaker_model i_spk (.clk, .clr, .tonePlainOut, .toneGatedOut, .amplitudePwmOut, .half, .edges,
      .ampHigh, .gatedHigh);
   always #2.5 clk = ~clk;
   // verdict
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // compare a value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // compare a measured count
   task automatic chkn(input int got, input int exp);
      checks_done++;
      if (got != exp)
      begin
         errors++;
         $display("[ERR] %0t count %0d exp %0d", $time, got, exp);
      end
   endtask
   // one bus transfer, held until ready is sampled
   task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [17:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task automatic rdc(input logic [17:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask
   // settle, clear the speaker counts, then listen n cycles
   task automatic pulse(input int n);
      repeat (300) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   // stop, set divider and fields, start, then time one tone half period
   task automatic tone(input logic [7:0] c, input logic [3:0] d, input int exp);
      wr(CTL, 32'h0);
      wr(DIV, {28'h0, d});
      wr(CTL, {24'h0, c});
      clr <= 1'b1;
      wr(CTL, {24'h0, c | 8'h80});
      clr <= 1'b0;
      chk({31'h0, tonePlainOut | toneGatedOut}, 32'h0);
      wait (edges >= 2);
      #1;
      chkn(half, exp);
   endtask
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rdc(CTL, 32'h0);
      rdc(AMP, 32'h0);
      rdc(DIV, 32'h0);
      wr(DIV, 32'hff);
      rdc(DIV, 32'hf);
      wr(BITW, 32'hb);
      rdc(CTL, 32'h8);
      wr(BITW, 32'h3);
      rdc(CTL, 32'h0);
      rdc(18'h3_ff10, 32'h0);
      chk({31'h0, se}, 32'h1);
      // a write without the low byte strobe must leave the register alone
      pstrb <= 4'he;
      wr(AMP, 32'h55);
      pstrb <= 4'hf;
      rdc(AMP, 32'h0);
      // a misaligned address answers with an error and reads zero
      rdc(18'h3_ff01, 32'h0);
      chk({31'h0, se}, 32'h1);
      for (int c = 0; c < 8; c++)
         tone(8'(c), 4'h0, 17 << (6 - c[0] + c[1] + 2 * c[2]));
      tone(8'h00, 4'hf, 32 << 6);
      wr(AMP, 32'h7f);
      tone(8'h08, 4'h5, 22 << 6);
      chkn(ampHigh, 0);
      chk({31'h0, clockOutFunction}, 32'h1);
      wr(AMP, 32'h0);
      pulse(2000);
      chkn(gatedHigh, 0);
      tone(8'h01, 4'h0, 17 << 5);
      foreach (codes[i])
      begin
         wr(AMP, codes[i]);
         pulse(1280);
         chkn(ampHigh, codes[i] == 32'h0 ? 0 : 10 * (int'(codes[i]) + 1));
      end
      wr(CTL, 32'h1);
      repeat (4) @(posedge clk);
      #1;
      chk({29'h0, tonePlainOut, toneGatedOut, amplitudePwmOut}, 32'h0);
      report_and_stop;
   end
   // watchdog
   initial
   begin
      #450000;
      errors++;
      report_and_stop;
   end
endmodule // test_sound_tone_generator
`default_nettype wire

// ===== rtl/amp_pwm_unit.sv
// 7-bit amplitude pwm counter and comparator
`timescale 1ns/1ps
`default_nettype none
`include "sound_tone_consts.svh"
module amp_pwm_unit
   import sound_tone_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   tone_pwm_if.unit pw
);

   logic [`AMP_CNT_W-1:0] cnt_q;
   logic [`AMP_CNT_W-1:0] cnt_d;
   logic pwm_q;
   logic pwm_d;
   logic [7:0] thresh;

   // period counter runs on the generator input clock, cleared while stopped
   always_comb
   begin
      thresh = (pw.level == '0) ? 8'h00 : ({1'b0, pw.level} + 8'h01);
      cnt_d = cnt_q;
      pwm_d = 1'b0;
      if (!pw.run)
      begin
         cnt_d = '0;
      end
      else
      begin
         if (pw.genTick)
         begin
            cnt_d = cnt_q + 7'h01;
         end
         pwm_d = ({1'b0, cnt_q} < thresh);
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_q <= '0;
         pwm_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         pwm_q <= pwm_d;
      end
   end

   assign pw.pwm = pwm_q;

endmodule // amp_pwm_unit
`default_nettype wire

// ===== rtl/sound_tone_consts.svh
// constants for the sound tone generator: offsets, fields, reset values, counts
`ifndef SOUND_TONE_CONSTS_SVH
`define SOUND_TONE_CONSTS_SVH

// register indices; byte address is four times the index
`define TONE_IDX_CTRL 16'hffc0
`define TONE_IDX_AMP 16'hffc1
`define TONE_IDX_DIV 16'hffc2
`define TONE_IDX_BITOP 16'hffc3
`define TONE_ADDR_W 18
`define TONE_WORD_LSB 2'h0

// tone_control field positions
`define CTRL_RUN_BIT 3'h7
`define CTRL_OSEL_BIT 3'h3
`define CTRL_PHI_BIT 3'h2
`define CTRL_PMID_BIT 3'h1
`define CTRL_PLO_BIT 3'h0

// writable bit masks, reserved bits read zero
`define CTRL_MASK 8'h8f
`define AMP_MASK 8'h7f
`define DIV_MASK 8'h0f

// reset values
`define CTRL_RESET 8'h00
`define AMP_RESET 8'h00
`define DIV_RESET 8'h00

// single-bit write port layout: bit number in [2:0], value in [3]
`define BITOP_VAL_BIT 5'h03

// prescale exponent for code 00 with the main-clock halving, and divider offset
`define PRE_EXP_BASE 4'h6
`define DIV_OFFSET 5'h11
`define PRE_W 9

// counter width and pwm full count
`define AMP_CNT_W 7
`define PWM_FULL 8'h80

`endif

// ===== rtl/sound_tone_generator.sv
// sound tone generator: apb registers, prescaler, tone divider and output select
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sound_tone_consts.svh"
module sound_tone_generator
   import sound_tone_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TONE_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tonePlainOut,
   output logic toneGatedOut,
   output logic amplitudePwmOut,
   output logic clockOutFunction
);

   tone_pwm_if pwIf ();

   // register state
   reg8_t ctrl_q;
   reg8_t ctrl_d;
   reg8_t amp_q;
   reg8_t amp_d;
   reg8_t div_q;
   reg8_t div_d;

   // bus answer state
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic ready_q;
   logic ready_d;
   logic err_q;
   logic err_d;

   // generator state
   logic [`PRE_W-1:0] pre_q;
   logic [`PRE_W-1:0] pre_d;
   logic [4:0] toneCnt_q;
   logic [4:0] toneCnt_d;
   logic tone_q;
   logic tone_d;

   // output registers
   logic plain_q;
   logic plain_d;
   logic gated_q;
   logic gated_d;
   logic ampOut_q;
   logic ampOut_d;
   logic clkFn_q;
   logic clkFn_d;

   // decode helpers
   logic [15:0] idx;
   logic wordAligned;
   logic setupPhase;
   logic accessDone;
   logic wrByte;
   logic hitCtrl;
   logic hitAmp;
   logic hitDiv;
   logic hitBitop;
   logic [2:0] bitNum;

   // control fields
   logic runEnable;
   logic outputSelect;
   preSel_t preSel;
   logic prescaleLo;
   logic [3:0] preExp;
   logic [`PRE_W-1:0] preTerm;
   logic preTick;
   logic genTick;
   logic [4:0] toneTerm;

   assign idx = paddr[`TONE_ADDR_W-1:2];
   assign wordAligned = (paddr[1:0] == `TONE_WORD_LSB);
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & ready_q;
   assign wrByte = accessDone & pwrite & pstrb[0];
   assign hitCtrl = wordAligned & (idx == `TONE_IDX_CTRL);
   assign hitAmp = wordAligned & (idx == `TONE_IDX_AMP);
   assign hitDiv = wordAligned & (idx == `TONE_IDX_DIV);
   assign hitBitop = wordAligned & (idx == `TONE_IDX_BITOP);
   assign bitNum = pwdata[2:0];

   assign runEnable = ctrl_q[`CTRL_RUN_BIT];
   assign outputSelect = ctrl_q[`CTRL_OSEL_BIT];
   assign preSel = preSel_t'({ctrl_q[`CTRL_PHI_BIT], ctrl_q[`CTRL_PMID_BIT]});
   assign prescaleLo = ctrl_q[`CTRL_PLO_BIT];

   // register writes: byte writes, plus single-bit writes to control
   always_comb
   begin
      ctrl_d = ctrl_q;
      amp_d = amp_q;
      div_d = div_q;
      if (wrByte && hitCtrl)
      begin
         ctrl_d = pwdata[7:0] & `CTRL_MASK;
      end
      if (wrByte && hitBitop)
      begin
         ctrl_d[bitNum] = pwdata[`BITOP_VAL_BIT];
         ctrl_d = ctrl_d & `CTRL_MASK;
      end
      if (wrByte && hitAmp)
      begin
         amp_d = pwdata[7:0] & `AMP_MASK;
      end
      if (wrByte && hitDiv)
      begin
         div_d = pwdata[7:0] & `DIV_MASK;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_q <= `CTRL_RESET;
         amp_q <= `AMP_RESET;
         div_q <= `DIV_RESET;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         amp_q <= amp_d;
         div_q <= div_d;
      end
   end

   // apb answer: read data and ready prepared during the setup cycle
   always_comb
   begin
      rdata_d = rdata_q;
      ready_d = setupPhase;
      err_d = 1'b0;
      if (setupPhase)
      begin
         rdata_d = 32'h0000_0000;
         err_d = ~(hitCtrl | hitAmp | hitDiv | hitBitop);
         if (!pwrite)
         begin
            if (hitCtrl)
            begin
               rdata_d = {24'h00_0000, ctrl_q};
            end
            else if (hitAmp)
            begin
               rdata_d = {24'h00_0000, amp_q};
            end
            else if (hitDiv)
            begin
               rdata_d = {24'h00_0000, div_q};
            end
            else
            begin
               rdata_d = 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
      end
   end

   // prescaler: one counter covers the main-clock halving and the 2^5..2^8 stage
   always_comb
   begin
      preExp = `PRE_EXP_BASE - {3'h0, prescaleLo} + {2'h0, preSel};
      preTerm = `PRE_W'((10'h001 << preExp) - 10'h001);
      preTick = runEnable & (pre_q == preTerm);
      genTick = runEnable & (prescaleLo | pre_q[0]);
      pre_d = '0;
      if (runEnable)
      begin
         pre_d = preTick ? '0 : (pre_q + `PRE_W'(1));
      end
   end

   // tone divider: toggles after divider plus 17 counter input ticks
   always_comb
   begin
      toneTerm = `DIV_OFFSET - 5'h01 + {1'b0, div_q[3:0]};
      toneCnt_d = toneCnt_q;
      tone_d = tone_q;
      if (!runEnable)
      begin
         toneCnt_d = 5'h00;
         tone_d = 1'b0;
      end
      else if (preTick)
      begin
         if (toneCnt_q == toneTerm)
         begin
            toneCnt_d = 5'h00;
            tone_d = ~tone_q;
         end
         else
         begin
            toneCnt_d = toneCnt_q + 5'h01;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pre_q <= '0;
         toneCnt_q <= 5'h00;
         tone_q <= 1'b0;
      end
      else
      begin
         pre_q <= pre_d;
         toneCnt_q <= toneCnt_d;
         tone_q <= tone_d;
      end
   end

   // amplitude pwm unit
   assign pwIf.run = runEnable;
   assign pwIf.genTick = genTick;
   assign pwIf.level = amp_q[6:0];

   amp_pwm_unit pwmUnit (
      .clk(clk),
      .srst(srst),
      .pw(pwIf.unit)
   );

   // output selection, speaker pins held low while stopped; clockOutFunction follows the select bit
   always_comb
   begin
      plain_d = runEnable & ~outputSelect & tone_q;
      gated_d = runEnable & outputSelect & tone_q & pwIf.pwm;
      ampOut_d = runEnable & ~outputSelect & pwIf.pwm;
      clkFn_d = outputSelect;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         plain_q <= 1'b0;
         gated_q <= 1'b0;
         ampOut_q <= 1'b0;
         clkFn_q <= 1'b0;
      end
      else
      begin
         plain_q <= plain_d;
         gated_q <= gated_d;
         ampOut_q <= ampOut_d;
         clkFn_q <= clkFn_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;
   assign tonePlainOut = plain_q;
   assign toneGatedOut = gated_q;
   assign amplitudePwmOut = ampOut_q;
   assign clockOutFunction = clkFn_q;

endmodule // sound_tone_generator
`default_nettype wire

// ===== rtl/sound_tone_pkg.sv
// types shared by the sound tone generator modules
package sound_tone_pkg;

   typedef logic [7:0] reg8_t;
   typedef logic [6:0] ampLevel_t;
   typedef logic [3:0] divField_t;

   // 5-bit counter input divide selection
   typedef enum logic [1:0] {
      PRE_DIV32 = 2'h0,
      PRE_DIV64 = 2'h1,
      PRE_DIV128 = 2'h2,
      PRE_DIV256 = 2'h3
   } preSel_t;

endpackage

// ===== rtl/tone_pwm_if.sv
// carrier between the tone core and the amplitude pwm unit
`timescale 1ns/1ps
`default_nettype none
interface tone_pwm_if;
   import sound_tone_pkg::*;

   logic run;
   logic genTick;
   ampLevel_t level;
   logic pwm;

   modport core (output run, output genTick, output level, input pwm);
   modport unit (input run, input genTick, input level, output pwm);

endinterface
`default_nettype wire
